// *** design/pulse_req_fifo.sv ***
// Purpose: Small FIFO of pulse requests toward the pulse generator.
// Assumes: Single clock, pushes ignored when full.
// Notes:   Depth need not be a power of two.
`timescale 1ns/1ps
`default_nettype none

module pulse_req_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 4
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
    localparam logic [PW:0]   FULL = (PW + 1)'(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PW-1:0]    wr_ptr_r;
    logic [PW-1:0]    rd_ptr_r;
    logic [PW:0]      cnt_r;

    wire push = in_valid_i & in_ready_o;
    wire pop  = out_valid_o & out_ready_i;

    assign in_ready_o  = (cnt_r != FULL);
    assign out_valid_o = (cnt_r != '0);
    assign out_data_o  = mem_r[rd_ptr_r];

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            cnt_r    <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == LAST) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == LAST) ? '0 : rd_ptr_r + 1'b1;
            end
            cnt_r <= cnt_r + (PW + 1)'(push) - (PW + 1)'(pop);
        end
    end

endmodule : pulse_req_fifo

`default_nettype wire

// *** design/sync_pulse_trigger.sv ***
// Purpose: Per-channel sync pulse trigger generation with upstream
//          shift buffers, busy and fault flags, interval filtering.
// Assumes: Host commands arrive as one-cycle pulses on sys_clk_i.
// Notes:   Two channels, fully independent except the timer delay.
`timescale 1ns/1ps
`default_nettype none

`include "sync_trig_params.svh"

module sync_pulse_trigger
    import sync_trig_pkg::*;
#(
    parameter int NCH        = 2,
    parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
    input  wire logic                    sys_clk_i,
    input  wire logic                    rst_i,
    input  wire logic [NCH-1:0]          cfg_wr_i,
    input  wire chan_cfg_s [NCH-1:0]     cfg_i,
    input  wire host_cmd_s [NCH-1:0]     cmd_i,
    input  wire logic                    dev_ctrl_wr_i,
    input  wire logic [`DCR_W-1:0]       dev_ctrl_data_i,
    input  wire logic [`TIMER_W-1:0]     chan_delay_us_i,
    input  wire logic [NCH-1:0]          sync_pin_i,
    input  wire logic [NCH-1:0]          pulse_ready_i,
    input  wire logic [NCH-1:0]          gen_active_i,
    output logic [NCH-1:0]               pulse_valid_o,
    output logic [NCH-1:0]               pulse_long_o,
    output logic [NCH-1:0]               pulse_hold_o,
    output logic [NCH-1:0]               rx_freeze_o,
    output logic [NCH-1:0]               busy_o,
    output logic [NCH-1:0]               fault_o,
    output logic [NCH-1:0]               mode_buffered_o
);

    localparam logic [`US_DIV_W-1:0] US_LAST = `US_DIV_W'(`CYC_PER_US - 1);

    // Reset code for one channel's buffer
    function automatic logic [`DCR_W-1:0] chan_reset_code(input int ch);
        chan_reset_code = (ch == 0) ? `DCR_RESET_CH1 : `DCR_RESET_CH2;
    endfunction : chan_reset_code

    // Buffered modes take their pulse type from the shift buffer
    function automatic logic is_buffered(input trig_mode_e m);
        is_buffered = (m == TRIG_SPI_BUF) || (m == TRIG_PIN_BUF) ||
                      (m == TRIG_TIMER);
    endfunction : is_buffered

    // Microsecond tick shared by interval and delay timers
    logic [`US_DIV_W-1:0] us_div_r;
    logic                 us_tick_r;

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            us_div_r  <= '0;
            us_tick_r <= 1'b0;
        end else begin
            us_div_r  <= (us_div_r == US_LAST) ? '0 : us_div_r + 1'b1;
            us_tick_r <= (us_div_r == US_LAST);
        end
    end

    // Per-channel signals visible to the delay logic
    logic [NCH-1:0] tmr_fire;
    logic [NCH-1:0] tmr_accept;
    logic [NCH-1:0] in_timer;

    // Inter-channel delay: channel 2 fires this long after channel 1
    logic [`TIMER_W-1:0] dly_cnt_r;
    logic                dly_run_r;
    logic                kick_pend_r;

    wire dly_start = tmr_accept[0] & in_timer[0];
    wire dly_done  = dly_run_r & us_tick_r & (dly_cnt_r <= `TIMER_W'(1));
    wire dly_zero  = dly_start & (chan_delay_us_i == '0);
    wire lockstep  = in_timer[0] & in_timer[NCH-1];

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            dly_cnt_r   <= '0;
            dly_run_r   <= 1'b0;
            kick_pend_r <= 1'b0;
        end else begin
            if (dly_start) begin
                dly_cnt_r <= chan_delay_us_i;
                dly_run_r <= (chan_delay_us_i != '0);
            end else if (dly_run_r && us_tick_r) begin
                dly_cnt_r <= dly_cnt_r - 1'b1;
                dly_run_r <= ~dly_done;
            end
            // A kick left over from a lone channel 1 run must not leak
            if ((dly_done || dly_zero) && lockstep) begin
                kick_pend_r <= 1'b1;
            end else if (tmr_accept[NCH-1] || !lockstep) begin
                kick_pend_r <= 1'b0;
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            chan_cfg_s                  cfg_r;
            logic [`UDB_BITS-1:0]       buf_r;
            logic [`UDB_BITS-1:0]       buf_nxt;
            logic [`MSG_LEN_W-1:0]      left_r;
            logic [`MSG_LEN_W-1:0]      left_nxt;
            logic                       busy_r;
            logic                       busy_nxt;
            logic                       fault_r;
            logic [`TIMER_W-1:0]        tmr_r;
            logic                       out_valid_r;
            logic                       out_long_r;
            logic                       hold_r;
            logic                       freeze_r;
            logic                       bufd_r;
            logic                       pin_lvl;
            logic                       pin_rise;
            logic                       fifo_in_ready;
            logic                       fifo_out_valid;
            logic                       fifo_out_long;
            logic                       fifo_rd_ready;

            trig_pin_sync u_pin (
                .clk_i   (sys_clk_i),
                .rst_i   (rst_i),
                .pin_i   (sync_pin_i[g]),
                .level_o (pin_lvl),
                .rise_o  (pin_rise)
            );

            // Mode decode
            wire mode_spi   = (cfg_r.mode == TRIG_SPI) ||
                              (cfg_r.mode == TRIG_SPI_BUF);
            wire mode_pin   = (cfg_r.mode == TRIG_PIN) ||
                              (cfg_r.mode == TRIG_PIN_BUF);
            wire buffered   = is_buffered(cfg_r.mode);
            assign in_timer[g] = (cfg_r.mode == TRIG_TIMER);

            // Interval window closed means a trigger is filtered out
            wire window_open = (tmr_r == '0);

            // Channel 2 follows channel 1 by the delay when both run timers
            wire own_fire    = in_timer[g] & window_open;
            assign tmr_fire[g] = (g != 0 && lockstep) ? kick_pend_r
                                                      : own_fire;

            wire ext_req  = (mode_spi & cmd_i[g].spi_trig) |
                            (mode_pin & pin_rise);
            wire trig_req = in_timer[g] ? tmr_fire[g]
                                        : (ext_req & window_open);

            // Timer requests wait for room; external ones are refused
            wire accept  = trig_req & fifo_in_ready;
            wire refused = ext_req & window_open & ~fifo_in_ready;
            assign tmr_accept[g] = accept;

            // Confirmed data present decides whether a bit is consumed
            wire use_bit = buffered & busy_r;
            wire bit_out = buf_r[0];
            wire gap     = use_bit & ~cfg_r.enc_pw & ~bit_out;
            wire bit_long = use_bit & cfg_r.enc_pw & bit_out;

            // Unbuffered SPI carries its own type, pin starts short
            wire req_long = buffered ? bit_long
                          : (mode_spi & cmd_i[g].spi_trig_long);
            wire emit     = accept & ~gap;
            wire shift    = accept & use_bit;

            wire ch_reset = dev_ctrl_wr_i &
                            (dev_ctrl_data_i == chan_reset_code(g));
            wire wr_ok    = cmd_i[g].buf_wr & ~busy_r;
            wire wr_bad   = cmd_i[g].buf_wr & busy_r;
            wire confirm  = cmd_i[g].confirm & ~busy_r &
                            (cfg_r.msg_len != '0);
            wire fault_set = wr_bad | refused;

            always_comb begin
                buf_nxt  = buf_r;
                left_nxt = left_r;
                busy_nxt = busy_r;
                if (ch_reset) begin
                    buf_nxt  = '0;
                    left_nxt = '0;
                    busy_nxt = 1'b0;
                end else begin
                    if (wr_ok) begin
                        buf_nxt[cmd_i[g].buf_idx*`UDB_WORD_W +: `UDB_WORD_W]
                            = cmd_i[g].buf_data;
                    end
                    if (confirm) begin
                        left_nxt = cfg_r.msg_len;
                        busy_nxt = 1'b1;
                    end
                    if (shift) begin
                        buf_nxt  = {1'b0, buf_r[`UDB_BITS-1:1]};
                        left_nxt = left_r - 1'b1;
                        busy_nxt = (left_r != `MSG_LEN_W'(1));
                    end
                end
            end

            always_ff @(posedge sys_clk_i or posedge rst_i) begin
                if (rst_i) begin
                    cfg_r.mode        <= TRIG_PIN;
                    cfg_r.enc_pw      <= `CFG_ENC_PW_RST;
                    cfg_r.msg_len     <= `CFG_MSG_LEN_RST;
                    cfg_r.interval_us <= `CFG_INTERVAL_RST;
                end else if (cfg_wr_i[g]) begin
                    cfg_r <= cfg_i[g];
                end
            end

            always_ff @(posedge sys_clk_i or posedge rst_i) begin
                if (rst_i) begin
                    buf_r  <= '0;
                    left_r <= '0;
                    busy_r <= 1'b0;
                end else begin
                    buf_r  <= buf_nxt;
                    left_r <= left_nxt;
                    busy_r <= busy_nxt;
                end
            end

            // Set wins over a clear in the same cycle
            always_ff @(posedge sys_clk_i or posedge rst_i) begin
                if (rst_i) begin
                    fault_r <= 1'b0;
                end else if (fault_set) begin
                    fault_r <= 1'b1;
                end else if (cmd_i[g].fault_clr) begin
                    fault_r <= 1'b0;
                end
            end

            // Interval reload on every accepted request
            always_ff @(posedge sys_clk_i or posedge rst_i) begin
                if (rst_i) begin
                    tmr_r <= '0;
                end else if (accept) begin
                    tmr_r <= cfg_r.interval_us;
                end else if (us_tick_r && tmr_r != '0) begin
                    tmr_r <= tmr_r - 1'b1;
                end
            end

            pulse_req_fifo #(
                .WIDTH (1),
                .DEPTH (FIFO_DEPTH)
            ) u_fifo (
                .clk_i       (sys_clk_i),
                .rst_i       (rst_i),
                .in_valid_i  (emit),
                .in_ready_o  (fifo_in_ready),
                .in_data_i   (req_long),
                .out_valid_o (fifo_out_valid),
                .out_ready_i (fifo_rd_ready),
                .out_data_o  (fifo_out_long)
            );

            // Output stage keeps every port on a flip-flop
            assign fifo_rd_ready = ~out_valid_r | pulse_ready_i[g];

            always_ff @(posedge sys_clk_i or posedge rst_i) begin
                if (rst_i) begin
                    out_valid_r <= 1'b0;
                    out_long_r  <= 1'b0;
                end else if (fifo_rd_ready) begin
                    out_valid_r <= fifo_out_valid;
                    out_long_r  <= fifo_out_long;
                end
            end

            // Pin length extends the pulse only without the buffer
            always_ff @(posedge sys_clk_i or posedge rst_i) begin
                if (rst_i) begin
                    hold_r   <= 1'b0;
                    freeze_r <= 1'b0;
                    bufd_r   <= 1'b0;
                end else begin
                    bufd_r   <= buffered;
                    hold_r   <= (cfg_r.mode == TRIG_PIN) & pin_lvl;
                    freeze_r <= gen_active_i[g] |
                                (out_valid_r & pulse_ready_i[g]);
                end
            end

            // Each channel drives only its own bit
            assign pulse_valid_o[g]   = out_valid_r;
            assign pulse_long_o[g]    = out_long_r;
            assign pulse_hold_o[g]    = hold_r;
            assign rx_freeze_o[g]     = freeze_r;
            assign busy_o[g]          = busy_r;
            assign fault_o[g]         = fault_r;
            assign mode_buffered_o[g] = bufd_r;
        end
    endgenerate

endmodule : sync_pulse_trigger

`default_nettype wire

// *** design/trig_pin_sync.sv ***
// Purpose: Synchronise and filter one external trigger pin.
// Assumes: Pin is asynchronous to sys_clk_i.
// Notes:   A change counts once the second and third stages agree.
`timescale 1ns/1ps
`default_nettype none

module trig_pin_sync (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic pin_i,
    output logic      level_o,
    output logic      rise_o
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic level_r;

    // Stage one feeds stage two only
    wire agree     = (s2_r == s3_r);
    wire level_nxt = agree ? s3_r : level_r;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s1_r    <= 1'b0;
            s2_r    <= 1'b0;
            s3_r    <= 1'b0;
            level_r <= 1'b0;
            rise_o  <= 1'b0;
        end else begin
            s1_r    <= pin_i;
            s2_r    <= s1_r;
            s3_r    <= s2_r;
            level_r <= level_nxt;
            rise_o  <= level_nxt & ~level_r;
        end
    end

    assign level_o = level_r;

endmodule : trig_pin_sync

`default_nettype wire

// *** shared/sync_trig_params.svh ***
// Purpose: Timing counts, reset values and command codes for the sync
//          pulse trigger and upstream buffer block.
// Assumes: 40 MHz system clock.
// Notes:   Definitions only.
`ifndef SYNC_TRIG_PARAMS_SVH
`define SYNC_TRIG_PARAMS_SVH

`define CLK_PERIOD_NS     25
`define US_IN_NS          1000
// Cycles per microsecond tick, derived from the clock period
`define CYC_PER_US        (`US_IN_NS / `CLK_PERIOD_NS)
`define US_DIV_W          6

`define UDB_BITS          64
`define UDB_WORD_W        16
`define UDB_IDX_W         2
`define MSG_LEN_W         7
`define TIMER_W           16

`define FIFO_DEPTH        4

// Device control register values that reset one channel's buffer
`define DCR_W             16
`define DCR_RESET_CH1     16'h00ff
`define DCR_RESET_CH2     16'hff00

// Reset values of the per-channel configuration
`define CFG_MSG_LEN_RST   7'h00
`define CFG_INTERVAL_RST  16'h0000
`define CFG_ENC_PW_RST    1'h0

`endif

// *** shared/sync_trig_pkg.sv ***
// Purpose: Types shared by the sync pulse trigger design.
// Assumes: Constants come from sync_trig_params.svh.
// Notes:   Packed carriers only.
`include "sync_trig_params.svh"

package sync_trig_pkg;

    typedef enum logic [2:0] {
        TRIG_SPI       = 3'b000,
        TRIG_SPI_BUF   = 3'b001,
        TRIG_PIN       = 3'b010,
        TRIG_PIN_BUF   = 3'b011,
        TRIG_TIMER     = 3'b100
    } trig_mode_e;

    typedef struct packed {
        trig_mode_e                  mode;
        logic                        enc_pw;
        logic [`MSG_LEN_W-1:0]       msg_len;
        logic [`TIMER_W-1:0]         interval_us;
    } chan_cfg_s;

    typedef struct packed {
        logic                        buf_wr;
        logic [`UDB_IDX_W-1:0]       buf_idx;
        logic [`UDB_WORD_W-1:0]      buf_data;
        logic                        confirm;
        logic                        spi_trig;
        logic                        spi_trig_long;
        logic                        fault_clr;
    } host_cmd_s;

endpackage : sync_trig_pkg

// *** testbench/pulse_gen_model.sv ***
// Purpose: Model of the sync pulse generator on the far side.
// Assumes: Long pulse 8 cycles, short 4; stall holds ready low.
// Notes:   Takes a request only when idle and not stalled.
`timescale 1ns/1ps
`default_nettype none
module pulse_gen_model (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic [1:0] stall_i,
    input  wire logic [1:0] valid_i,
    input  wire logic [1:0] long_i,
    output logic      [1:0] ready_o,
    output logic      [1:0] active_o
);
    int cnt [2];
    always @(posedge clk_i or posedge rst_i) begin
        for (int c = 0; c < 2; c++) begin
            if (rst_i)
                cnt[c] <= 0;
            else if (valid_i[c] && ready_o[c])
                cnt[c] <= long_i[c] ? 8 : 4;
            else if (cnt[c] > 0)
                cnt[c] <= cnt[c] - 1;
        end
    end
    always_comb begin
        for (int c = 0; c < 2; c++) begin
            active_o[c] = cnt[c] > 0;
            ready_o[c]  = !stall_i[c] && cnt[c] == 0;
        end
    end
endmodule : pulse_gen_model
`default_nettype wire

// *** testbench/sync_pulse_trigger_upstream_buffer_tb.sv ***
// Purpose: Self-checking bench of the sync pulse trigger block.
// Assumes: Far side modelled by pulse_gen_model.
// Notes:   Pulses taken are queued per channel and compared.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_count++; \
    $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module sync_pulse_trigger_upstream_buffer_tb;
    import sync_trig_pkg::*;
    logic            sys_clk_i = 0;
    logic            rst_i = 1;
    logic [1:0]      cfg_wr_i = '0;
    chan_cfg_s [1:0] cfg_i = '0;
    host_cmd_s [1:0] cmd_i = '0;
    logic            dev_ctrl_wr_i = 0;
    logic [15:0]     dev_ctrl_data_i = '0;
    logic [15:0]     chan_delay_us_i = '0;
    logic [1:0]      sync_pin_i = '0;
    logic [1:0]      stall = '0;
    logic [1:0]      wi = '0;
    logic [1:0]      pulse_ready_i, gen_active_i, pulse_valid_o;
    logic [1:0]      pulse_long_o, pulse_hold_o, rx_freeze_o;
    logic [1:0]      busy_o, fault_o, mode_buffered_o;
    int              err_count = 0;
    int              checked = 0;
    logic            got [2][$];
    logic            exp_q [$];
    always #12.5 sys_clk_i = ~sys_clk_i;
    sync_pulse_trigger #(.NCH(2), .FIFO_DEPTH(4)) dut_u (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .cfg_wr_i(cfg_wr_i),
        .cfg_i(cfg_i), .cmd_i(cmd_i), .dev_ctrl_wr_i(dev_ctrl_wr_i),
        .dev_ctrl_data_i(dev_ctrl_data_i), .chan_delay_us_i(chan_delay_us_i),
        .sync_pin_i(sync_pin_i), .pulse_ready_i(pulse_ready_i),
        .gen_active_i(gen_active_i), .pulse_valid_o(pulse_valid_o),
        .pulse_long_o(pulse_long_o), .pulse_hold_o(pulse_hold_o),
        .rx_freeze_o(rx_freeze_o), .busy_o(busy_o), .fault_o(fault_o),
        .mode_buffered_o(mode_buffered_o));
    pulse_gen_model pg_u (.clk_i(sys_clk_i), .rst_i(rst_i), .stall_i(stall),
        .valid_i(pulse_valid_o), .long_i(pulse_long_o),
        .ready_o(pulse_ready_i), .active_o(gen_active_i));
    always @(posedge sys_clk_i) begin
        for (int c = 0; c < 2; c++)
            if (pulse_valid_o[c] && pulse_ready_i[c]) got[c].push_back(pulse_long_o[c]);
    end
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask : tick
    task automatic hc(input int c, input logic wr, input logic [15:0] d,
                      input logic cf, input logic tr, input logic lg,
                      input logic cl);
        tick(1);
        cmd_i[c] = '{wr, wi, d, cf, tr, lg, cl};
        tick(1);
        cmd_i[c] = '0;
    endtask : hc
    task automatic setcfg(input int c, input trig_mode_e m, input logic pw,
                          input int len, input int iv);
        tick(1);
        cfg_i[c] = '{m, pw, 7'(len), 16'(iv)};
        cfg_wr_i[c] = 1'b1;
        tick(1);
        cfg_wr_i[c] = 1'b0;
    endtask : setcfg
    // Pin held 6 cycles, long enough to pass the pin filter
    task automatic trig(input int c, input logic pin, input logic lg);
        if (pin) begin
            sync_pin_i[c] = 1'b1;
            tick(6);
            sync_pin_i[c] = 1'b0;
            tick(14);
        end else begin
            hc(c, 0, 16'h0000, 0, 1, lg, 0);
            tick(18);
        end
    endtask : trig
    task automatic match(input int c, input bit loose);
        tick(40);
        if (!loose) `CHK(got[c].size(), exp_q.size())
        for (int i = 0; i < exp_q.size(); i++) `CHK(got[c][i], exp_q[i])
        $display("test on channel %0d done", c);
        got[c].delete();
        exp_q.delete();
    endtask : match
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        #(60000 * 25);
        err_count++;
        tally_and_finish();
    end
    initial begin
        int          len;
        logic [15:0] w;
        logic [63:0] b;
        void'($urandom(3));
        chan_delay_us_i = 16'($urandom % 4);
        repeat (2) @(posedge sys_clk_i);
        #1;
        rst_i = 0;
        tick(1);
        `CHK(mode_buffered_o, 2'b00)
        `CHK(busy_o | fault_o | pulse_valid_o, 2'b00)
        for (int c = 0; c < 2; c++) begin
            setcfg(c, TRIG_SPI, 0, 0, 0);
            for (int lg = 0; lg < 2; lg++) begin
                trig(c, 0, lg[0]);
                exp_q.push_back(lg[0]);
            end
            match(c, 0);
            for (int k = 0; k < 4; k++) begin
                len = 8 + $urandom % 57;
                b = {$urandom, $urandom};
                setcfg(c, k[0] ? TRIG_PIN_BUF : TRIG_SPI_BUF, k[1], len, 0);
                trig(c, k[0], 1'b1);
                exp_q.push_back(1'b0);
                for (int j = 0; j < 4; j++) begin
                    wi = 2'(3 - j);
                    hc(c, 1, b[16*wi +: 16], 0, 0, 0, 0);
                end
                hc(c, 0, 16'h0000, 1, 0, 0, 0);
                tick(1);
                `CHK(busy_o[c], 1'b1)
                `CHK(mode_buffered_o[c], 1'b1)
                hc(c, 1, ~b[15:0], 0, 0, 0, 0);
                tick(1);
                `CHK(fault_o[c], 1'b1)
                `CHK(fault_o[1-c], 1'b0)
                for (int i = 0; i < len; i++) begin
                    trig(c, k[0], 1'b0);
                    if (k[1] || b[i]) exp_q.push_back(k[1] & b[i]);
                end
                `CHK(busy_o[c], 1'b0)
                trig(c, k[0], 1'b1);
                exp_q.push_back(1'b0);
                hc(c, 0, 16'h0000, 0, 0, 0, 1);
                tick(1);
                `CHK(fault_o[c], 1'b0)
                match(c, 0);
            end
            setcfg(c, TRIG_SPI_BUF, 1, 16, 0);
            hc(c, 1, 16'hffff, 0, 0, 0, 0);
            hc(c, 0, 16'h0000, 1, 0, 0, 0);
            tick(1);
            dev_ctrl_data_i = c ? 16'hff00 : 16'h00ff;
            dev_ctrl_wr_i = 1'b1;
            tick(1);
            dev_ctrl_wr_i = 1'b0;
            tick(1);
            `CHK(busy_o[c], 1'b0)
            trig(c, 0, 1'b0);
            exp_q.push_back(1'b0);
            match(c, 0);
        end
        // Output stalled: four in the queue plus one held request
        setcfg(1, TRIG_SPI, 0, 0, 0);
        stall[1] = 1'b1;
        repeat (7) hc(1, 0, 16'h0000, 0, 1, 0, 0);
        tick(1);
        `CHK(fault_o[1], 1'b1)
        stall[1] = 1'b0;
        repeat (5) exp_q.push_back(1'b0);
        match(1, 0);
        hc(1, 0, 16'h0000, 0, 0, 0, 1);
        w = 16'($urandom);
        setcfg(0, TRIG_SPI_BUF, 1, 4, 0);
        hc(0, 1, w, 0, 0, 0, 0);
        hc(0, 0, 16'h0000, 1, 0, 0, 0);
        setcfg(0, TRIG_TIMER, 1, 4, 1);
        tick(150);
        setcfg(0, TRIG_SPI, 0, 0, 0);
        for (int i = 0; i < 4; i++) exp_q.push_back(w[i]);
        match(0, 1);
        setcfg(0, TRIG_PIN, 0, 0, 2);
        sync_pin_i[0] = 1'b1;
        tick(9);
        `CHK(pulse_hold_o[0], 1'b1)
        sync_pin_i[0] = 1'b0;
        tick(6);
        `CHK(pulse_hold_o[0], 1'b0)
        trig(0, 1, 1'b0);
        exp_q.push_back(1'b0);
        match(0, 0);
        // Both timers: one pulse each, channel 2 after the delay
        chan_delay_us_i = 16'($urandom % 4);
        cfg_i = '{2{'{TRIG_TIMER, 1'b0, 7'h00, 16'h0005}}};
        cfg_wr_i = 2'b11;
        tick(1);
        cfg_wr_i = 2'b00;
        tick(150);
        `CHK(got[0].size(), 1)
        `CHK(got[1].size(), 1)
        tally_and_finish();
    end
endmodule : sync_pulse_trigger_upstream_buffer_tb
`default_nettype wire

// *** testbench/sync_trig_assertions.sv ***
// Purpose: Port checks of the sync pulse trigger block.
// Assumes: Channel 0 watched in depth; channel 1 logic is alike.
// Notes:   Bound onto the top module.
`timescale 1ns/1ps
`default_nettype none
module sync_trig_assertions
    import sync_trig_pkg::*;
#(
    parameter int NCH = 2
) (
    input wire logic                sys_clk_i,
    input wire logic                rst_i,
    input wire host_cmd_s [NCH-1:0] cmd_i,
    input wire logic                dev_ctrl_wr_i,
    input wire logic [15:0]         dev_ctrl_data_i,
    input wire logic [NCH-1:0]      pulse_ready_i,
    input wire logic [NCH-1:0]      gen_active_i,
    input wire logic [NCH-1:0]      pulse_valid_o,
    input wire logic [NCH-1:0]      pulse_long_o,
    input wire logic [NCH-1:0]      pulse_hold_o,
    input wire logic [NCH-1:0]      rx_freeze_o,
    input wire logic [NCH-1:0]      busy_o,
    input wire logic [NCH-1:0]      fault_o,
    input wire logic [NCH-1:0]      mode_buffered_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    a_busy_write_fault: assert property (
        busy_o[0] && cmd_i[0].buf_wr |=> fault_o[0])
        else $error("write while busy left fault low");
    a_clear_ch_one: assert property (
        dev_ctrl_wr_i && dev_ctrl_data_i == 16'h00ff && !cmd_i[0].confirm
        |=> !busy_o[0]) else $error("channel one reset kept busy");
    a_clear_ch_two: assert property (
        dev_ctrl_wr_i && dev_ctrl_data_i == 16'hff00 && !cmd_i[1].confirm
        |=> !busy_o[1]) else $error("channel two reset kept busy");
    a_freeze_follows: assert property (
        1'b1 |=> rx_freeze_o[0] ==
        $past(gen_active_i[0] | (pulse_valid_o[0] & pulse_ready_i[0])))
        else $error("freeze does not track pulse");
    a_fault_sticky: assert property (
        fault_o[0] && !cmd_i[0].fault_clr |=> fault_o[0])
        else $error("fault dropped without clear");
    a_busy_from_confirm: assert property (
        $rose(busy_o[0]) |-> $past(cmd_i[0].confirm))
        else $error("busy rose without confirm");
    a_hold_unbuffered: assert property (
        pulse_hold_o[0] |-> !mode_buffered_o[0])
        else $error("hold level in buffered mode");
    a_request_stands: assert property (
        pulse_valid_o[0] && !pulse_ready_i[0]
        |=> pulse_valid_o[0] && $stable(pulse_long_o[0]))
        else $error("request changed before taken");
endmodule : sync_trig_assertions
bind sync_pulse_trigger sync_trig_assertions #(.NCH(NCH)) chk_u (
    .sys_clk_i, .rst_i, .cmd_i, .dev_ctrl_wr_i, .dev_ctrl_data_i,
    .pulse_ready_i, .gen_active_i, .pulse_valid_o, .pulse_long_o,
    .pulse_hold_o, .rx_freeze_o, .busy_o, .fault_o, .mode_buffered_o);
`default_nettype wire
